/* rtl/ee_target.sv */
// Serial EEPROM target end: bus decoding, page buffer, programming timer, array.
`timescale 1ns/1ps
`include "ee_consts.svh"
module ee_target
  import ee_pkg::*;
#(
  parameter int PROG_CYCLES = `EE_PROG_TIME_MS * `EE_CLK_KHZ,
  parameter int POR_CYCLES  = `EE_POR_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  ee_if.target            bus,
  input  wire logic [2:0] chip_select_pins,
  input  wire logic       write_protect,
  output logic            busy,
  output logic            ready
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int RW = $clog2(POR_CYCLES + 1);
  localparam int AW = `EE_MEM_AW;
  localparam int PA = `EE_PAGE_AW;

  // Pin synchronisers; the first stage of each feeds only its second stage.
  logic       scl_s1, scl_s2, scl_d;
  logic       sda_s1, sda_s2, sda_d;
  logic       wp_s1, wp_s2;
  logic [2:0] cs_s1, cs_s2;
  logic       rise, fall, start_seen, stop_seen;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
      cs_s1  <= 3'h0;
      cs_s2  <= 3'h0;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
      wp_s1  <= write_protect;
      wp_s2  <= wp_s1;
      cs_s1  <= chip_select_pins;
      cs_s2  <= cs_s1;
    end
  end

  // Bus events seen on the synchronised lines.
  assign rise       = scl_s2 && !scl_d;
  assign fall       = !scl_s2 && scl_d;
  assign start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_seen  = scl_s2 && scl_d && !sda_d && sda_s2;

  // Power-on reset stand-in: the bus is deaf until this count completes.
  logic [RW-1:0] por_cnt, next_por_cnt;

  always_comb begin
    next_por_cnt = por_cnt;
    if (por_cnt != RW'(POR_CYCLES)) begin
      next_por_cnt = por_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt <= '0;
      ready   <= 1'b0;
    end else begin
      por_cnt <= next_por_cnt;
      ready   <= (next_por_cnt == RW'(POR_CYCLES));
    end
  end

  // Protocol, page buffer bookkeeping and programming timer.
  ee_tgt_state_type st, next_st;
  logic [3:0]       bitn, next_bitn;
  logic [7:0]       shreg, next_shreg;
  logic [7:0]       rbyte, next_rbyte;
  logic [7:0]       ahi, next_ahi;
  logic [AW-1:0]    cnt, next_cnt;
  logic [AW-PA-1:0] prow, next_prow;
  logic [31:0]      pmask, next_pmask;
  logic [TW-1:0]    tmr, next_tmr;
  logic [5:0]       cptr, next_cptr;
  logic             rw, next_rw;
  logic             mack, next_mack;
  logic             drive, next_drive;
  logic             next_busy;
  logic             pb_we;
  logic             mem_we;
  logic [7:0]       pbuf [32];
  logic [7:0]       mem [`EE_MEM_BYTES];

  always_comb begin
    next_st    = st;
    next_bitn  = bitn;
    next_shreg = shreg;
    next_rbyte = rbyte;
    next_ahi   = ahi;
    next_cnt   = cnt;
    next_prow  = prow;
    next_pmask = pmask;
    next_tmr   = tmr;
    next_cptr  = cptr;
    next_rw    = rw;
    next_mack  = mack;
    next_drive = drive;
    next_busy  = busy;
    pb_we      = 1'b0;
    mem_we     = 1'b0;
    if (busy) begin
      // Every bus input is ignored; in each of the first 32 cycles one page slot is committed if its pmask bit is set.
      next_st    = EE_ST_IDLE;
      next_drive = 1'b0;
      if (cptr != `EE_PAGE_BYTES) begin
        mem_we    = pmask[cptr[PA-1:0]];
        next_cptr = cptr + 1'b1;
      end
      if (tmr == TW'(PROG_CYCLES - 1)) begin
        next_busy  = 1'b0;
        next_pmask = 32'h0000_0000;
      end else begin
        next_tmr = tmr + 1'b1;
      end
    end else if (!ready) begin
      next_st    = EE_ST_IDLE;
      next_drive = 1'b0;
    end else if (start_seen) begin
      // A restart drops any write not yet closed by a stop.
      next_st    = EE_ST_DEV;
      next_bitn  = 4'h0;
      next_drive = 1'b0;
      next_pmask = 32'h0000_0000;
    end else if (stop_seen) begin
      next_st    = EE_ST_IDLE;
      next_drive = 1'b0;
      if (st == EE_ST_WDATA && pmask != 32'h0000_0000 && !wp_s2) begin
        next_busy = 1'b1;
        next_tmr  = '0;
        next_cptr = 6'h00;
      end else begin
        next_pmask = 32'h0000_0000;
      end
    end else if (st != EE_ST_IDLE) begin
      if (rise) begin
        if (bitn < `EE_ACK_SLOT) begin
          next_shreg = {shreg[6:0], sda_s2};
        end else begin
          next_mack = !sda_s2;
        end
        next_bitn = bitn + 1'b1;
      end else if (fall) begin
        if (bitn == `EE_ACK_SLOT) begin
          if (st == EE_ST_RDATA) begin
            next_drive = 1'b0;
          end else if (st == EE_ST_DEV) begin
            if (shreg[7:4] == `EE_DEV_CODE && shreg[3:1] == cs_s2) begin
              next_drive = 1'b1;
              next_rw    = shreg[0];
            end else begin
              next_st = EE_ST_IDLE;
            end
          end else begin
            next_drive = 1'b1;
          end
        end else if (bitn == `EE_LAST_SLOT) begin
          next_bitn  = 4'h0;
          next_drive = 1'b0;
          unique case (st)
            EE_ST_DEV: begin
              if (rw) begin
                next_st    = EE_ST_RDATA;
                next_rbyte = mem[cnt];
                next_drive = !mem[cnt][7];
                next_cnt   = cnt + 1'b1;
              end else begin
                next_st = EE_ST_AHI;
              end
            end
            EE_ST_AHI: begin
              next_ahi = shreg;
              next_st  = EE_ST_ALO;
            end
            EE_ST_ALO: begin
              next_cnt = {ahi[AW-9:0], shreg};
              next_st  = EE_ST_WDATA;
            end
            EE_ST_WDATA: begin
              pb_we                    = 1'b1;
              next_pmask[cnt[PA-1:0]]  = 1'b1;
              next_prow                = cnt[AW-1:PA];
              next_cnt[PA-1:0]         = cnt[PA-1:0] + 1'b1;
            end
            EE_ST_RDATA: begin
              if (mack) begin
                next_rbyte = mem[cnt];
                next_drive = !mem[cnt][7];
                next_cnt   = cnt + 1'b1;
              end else begin
                next_st = EE_ST_IDLE;
              end
            end
            default: begin
              next_st = EE_ST_IDLE;
            end
          endcase
        end else if (st == EE_ST_RDATA) begin
          next_drive = !rbyte[3'(4'h7 - bitn)];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st    <= EE_ST_IDLE;
      bitn  <= 4'h0;
      shreg <= 8'h00;
      rbyte <= 8'h00;
      ahi   <= 8'h00;
      cnt   <= '0;
      prow  <= '0;
      pmask <= 32'h0000_0000;
      tmr   <= '0;
      cptr  <= 6'h00;
      rw    <= 1'b0;
      mack  <= 1'b0;
      drive <= 1'b0;
      busy  <= 1'b0;
    end else begin
      st    <= next_st;
      bitn  <= next_bitn;
      shreg <= next_shreg;
      rbyte <= next_rbyte;
      ahi   <= next_ahi;
      cnt   <= next_cnt;
      prow  <= next_prow;
      pmask <= next_pmask;
      tmr   <= next_tmr;
      cptr  <= next_cptr;
      rw    <= next_rw;
      mack  <= next_mack;
      drive <= next_drive;
      busy  <= next_busy;
    end
  end

  // Page buffer and array; the array only changes during programming.
  always_ff @(posedge clk_sys) begin
    if (pb_we) begin
      pbuf[cnt[PA-1:0]] <= shreg;
    end
    if (mem_we) begin
      mem[{prow, cptr[PA-1:0]}] <= pbuf[cptr[PA-1:0]];
    end
  end

  // The pin is only ever pulled low; a high comes from the pull-up.
  assign bus.t_sda_o  = 1'b0;
  assign bus.t_sda_oe = drive;
endmodule

/* common/ee_consts.svh */
// Named constants for the serial EEPROM target and its bus master.
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH

`define EE_DEV_CODE      4'ha
`define EE_MEM_AW        12
`define EE_MEM_BYTES     4096
`define EE_PAGE_AW       5
`define EE_PAGE_BYTES    6'h20
`define EE_ACK_SLOT      4'h8
`define EE_LAST_SLOT     4'h9
`define EE_CLK_MHZ       200
`define EE_CLK_KHZ       200000
`define EE_PROG_TIME_MS  5
`define EE_PWRUP_TIME_US 100
`define EE_POR_CYCLES    16
`define EE_QUARTER       50

`endif

/* common/ee_pkg.sv */
// Types shared by the serial EEPROM target and its bus master.
package ee_pkg;

  typedef enum logic [2:0] {
    EE_ST_IDLE,
    EE_ST_DEV,
    EE_ST_AHI,
    EE_ST_ALO,
    EE_ST_WDATA,
    EE_ST_RDATA
  } ee_tgt_state_type;

  typedef enum logic [3:0] {
    EE_M_WAIT,
    EE_M_IDLE,
    EE_M_START,
    EE_M_DEV,
    EE_M_AHI,
    EE_M_ALO,
    EE_M_WR,
    EE_M_RSTART,
    EE_M_RDEV,
    EE_M_RD,
    EE_M_STOP
  } ee_mst_state_type;

  typedef enum logic [1:0] {
    EE_CMD_WRITE,
    EE_CMD_READ_CUR,
    EE_CMD_READ_RAND
  } ee_cmd_kind_type;

endpackage

/* common/ee_if.sv */
// Two-wire bus carrier: clock from the master, open-drain data from both ends.
`timescale 1ns/1ps
interface ee_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic sda;

  // Wired-AND with pull-up: the line is low while either end drives a low.
  assign sda = !((m_sda_oe && !m_sda_o) || (t_sda_oe && !t_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport target (input scl, input sda, output t_sda_o, output t_sda_oe);
endinterface

/* rtl/ee_fifo.sv */
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module ee_fifo
  import ee_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      fill;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap at DEPTH, so a depth that is not a power of two still works.
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_fill = fill + 1'b1;
    end else if (pop && !push) begin
      next_fill = fill - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // Storage carries no reset; only entries below the fill level are ever read.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

/* rtl/ee_master.sv */
// Two-wire bus master end: command sequencing, clock divider and acknowledge polling.
`timescale 1ns/1ps
`include "ee_consts.svh"
module ee_master
  import ee_pkg::*;
#(
  parameter int QUARTER     = `EE_QUARTER,
  parameter int PWRUP_CYCLES = `EE_PWRUP_TIME_US * `EE_CLK_MHZ,
  parameter int FIFO_DEPTH  = 4
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  ee_if.master                 bus,
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  wire ee_cmd_kind_type cmd_kind,
  input  wire logic [2:0]      cmd_sel,
  input  wire logic [11:0]     cmd_addr,
  input  wire logic [4:0]      cmd_len,
  input  wire logic            wr_valid,
  output logic                 wr_ready,
  input  wire logic [7:0]      wr_data,
  output logic                 rd_valid,
  output logic [7:0]           rd_data,
  output logic                 done,
  output logic                 err
);
  localparam int QW = $clog2(QUARTER + 1);
  localparam int WW = $clog2(PWRUP_CYCLES + 1);

  // Returns {clock level, data level} for a state, quarter phase and data bit.
  function automatic logic [1:0] ee_lines(input ee_mst_state_type s,
                                          input logic [1:0] p, input logic b);
    unique case (s)
      EE_M_WAIT, EE_M_IDLE:     return 2'b11;
      EE_M_START, EE_M_RSTART:  return {(p == 2'h1) || (p == 2'h2), p < 2'h2};
      EE_M_STOP:                return {p != 2'h0, p >= 2'h2};
      default:                  return {(p == 2'h1) || (p == 2'h2), b};
    endcase
  endfunction

  logic sda_s1, sda_s2;
  logic [QW-1:0] qcnt;
  logic tick;
  ee_mst_state_type st, next_st;

  // Data line synchroniser and quarter-period divider.
  // The divider rests in idle, so the first quarter of a start is never cut short.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      qcnt   <= '0;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      qcnt   <= (tick || st == EE_M_IDLE) ? '0 : qcnt + 1'b1;
    end
  end
  assign tick = (qcnt == QW'(QUARTER - 1));

  logic       f_valid, f_ready;
  logic [7:0] f_data;

  // Write data is buffered; an empty buffer stretches the clock low.
  ee_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  ee_cmd_kind_type  kind, next_kind;
  logic [1:0]  ph, next_ph;
  logic [3:0]  bitn, next_bitn;
  logic [7:0]  txb, next_txb;
  logic [7:0]  rxb, next_rxb;
  logic [4:0]  cnt, next_cnt;
  logic [4:0]  len, next_len;
  logic [2:0]  sel, next_sel;
  logic [11:0] addr, next_addr;
  logic [WW-1:0] wcnt, next_wcnt;
  logic nack, next_nack, polling, next_polling, again, next_again, have, next_have;
  logic scl_o, next_scl, sda_hi, next_sda_hi;
  logic next_rd_valid, next_done, next_err;
  logic [7:0] next_rd_data;
  logic bit_val, go, byte_end;

  assign cmd_ready = (st == EE_M_IDLE);
  assign f_ready   = (st == EE_M_WR) && !have && (bitn == 4'h0) && (ph == 2'h0);
  assign go        = tick && !((st == EE_M_WR) && !have);
  assign byte_end  = go && (ph == 2'h3) && (bitn == `EE_ACK_SLOT);

  // Sequencing of start, address, data, stop and polling.
  always_comb begin
    next_st = st; next_kind = kind; next_ph = ph; next_bitn = bitn;
    next_txb = txb; next_rxb = rxb; next_cnt = cnt; next_len = len;
    next_sel = sel; next_addr = addr; next_wcnt = wcnt; next_nack = nack;
    next_polling = polling; next_again = again; next_have = have;
    next_rd_valid = 1'b0; next_rd_data = rd_data; next_done = 1'b0; next_err = 1'b0;
    if (st == EE_M_RD) begin
      bit_val = (bitn < `EE_ACK_SLOT) ? 1'b1 : (cnt == len);
    end else begin
      bit_val = (bitn < `EE_ACK_SLOT) ? txb[3'(4'h7 - bitn)] : 1'b1;
    end
    {next_scl, next_sda_hi} = ee_lines(st, ph, bit_val);
    if (f_ready && f_valid) begin
      next_txb  = f_data;
      next_have = 1'b1;
    end
    if (go && ph == 2'h2) begin
      if (bitn < `EE_ACK_SLOT) next_rxb = {rxb[6:0], sda_s2};
      else next_nack = sda_s2;
    end
    if (go && !(st == EE_M_WAIT || st == EE_M_IDLE)) begin
      next_ph = ph + 1'b1;
      if (ph == 2'h3 && bitn != `EE_ACK_SLOT) next_bitn = bitn + 1'b1;
    end
    unique case (st)
      EE_M_WAIT: begin
        if (wcnt == WW'(PWRUP_CYCLES)) next_st = EE_M_IDLE;
        else next_wcnt = wcnt + 1'b1;
      end
      EE_M_IDLE: begin
        if (cmd_valid) begin
          next_st = EE_M_START; next_kind = cmd_kind; next_sel = cmd_sel;
          next_addr = cmd_addr; next_len = cmd_len; next_ph = 2'h0;
          next_polling = 1'b0; next_again = 1'b0;
          // A byte count left over from the last command would shorten or lengthen this one.
          next_cnt = 5'h00;
        end
      end
      EE_M_START, EE_M_RSTART: begin
        if (go && ph == 2'h3) begin
          next_bitn = 4'h0;
          next_txb  = {`EE_DEV_CODE, sel,
                       (st == EE_M_RSTART) || (!polling && kind == EE_CMD_READ_CUR)};
          next_st   = (st == EE_M_RSTART) ? EE_M_RDEV : EE_M_DEV;
        end
      end
      EE_M_STOP: begin
        if (go && ph == 2'h3) begin
          if (again || polling) begin
            next_st = EE_M_START; next_again = 1'b0; next_cnt = 5'h00;
          end else begin
            next_st = EE_M_IDLE; next_done = 1'b1;
          end
        end
      end
      default: begin
        if (byte_end) begin
          next_bitn = 4'h0;
          next_st   = EE_M_STOP;
          if (next_nack && st != EE_M_RD) begin
            if (st == EE_M_DEV || st == EE_M_RDEV) next_again = 1'b1;
            else next_err = 1'b1;
          end else begin
            unique case (st)
              EE_M_DEV: begin
                if (polling) next_polling = 1'b0;
                else if (kind == EE_CMD_READ_CUR) next_st = EE_M_RD;
                else begin
                  next_st = EE_M_AHI; next_txb = {4'h0, addr[11:8]};
                end
              end
              EE_M_AHI: begin
                next_st = EE_M_ALO; next_txb = addr[7:0];
              end
              EE_M_ALO: begin
                next_have = 1'b0;
                next_st = (kind == EE_CMD_WRITE) ? EE_M_WR : EE_M_RSTART;
              end
              EE_M_WR: begin
                next_have = 1'b0;
                if (cnt == len) next_polling = 1'b1;
                else begin
                  next_st = EE_M_WR; next_cnt = cnt + 1'b1;
                end
              end
              EE_M_RDEV: next_st = EE_M_RD;
              EE_M_RD: begin
                next_rd_valid = 1'b1; next_rd_data = rxb;
                if (cnt != len) begin
                  next_st = EE_M_RD; next_cnt = cnt + 1'b1;
                end
              end
              default: next_st = EE_M_STOP;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= EE_M_WAIT; kind <= EE_CMD_WRITE; ph <= 2'h0; bitn <= 4'h0;
      txb <= 8'h00; rxb <= 8'h00; cnt <= 5'h00; len <= 5'h00; sel <= 3'h0;
      addr <= 12'h000; wcnt <= '0; nack <= 1'b0; polling <= 1'b0; again <= 1'b0;
      have <= 1'b0; scl_o <= 1'b1; sda_hi <= 1'b1; rd_valid <= 1'b0;
      rd_data <= 8'h00; done <= 1'b0; err <= 1'b0;
    end else begin
      st <= next_st; kind <= next_kind; ph <= next_ph; bitn <= next_bitn;
      txb <= next_txb; rxb <= next_rxb; cnt <= next_cnt; len <= next_len;
      sel <= next_sel; addr <= next_addr; wcnt <= next_wcnt; nack <= next_nack;
      polling <= next_polling; again <= next_again; have <= next_have;
      scl_o <= next_scl; sda_hi <= next_sda_hi; rd_valid <= next_rd_valid;
      rd_data <= next_rd_data; done <= next_done; err <= next_err;
    end
  end

  // The master alone drives the clock; data is pulled low only.
  assign bus.scl      = scl_o;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = !sda_hi;
endmodule

/* sim/ee_link_properties.sv */
// Protocol checker watching both ends of the two-wire link.
`timescale 1ns/1ps
module ee_link_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic sda
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Both ends may only pull low; a driven high would fight a low from the other end.
  AST_T_ODRAIN: assert property (t_sda_oe |-> !t_sda_o)
    else $error("target drives data high");
  AST_M_ODRAIN: assert property (m_sda_oe |-> !m_sda_o)
    else $error("master drives data high");
  // Target data may move only while the clock is low, else it fakes a start or stop.
  AST_T_MOVE_LOW: assert property ($changed(t_sda_oe) |-> !scl)
    else $error("target data moved with clock high");
  AST_T_DELAY: assert property ($changed(t_sda_oe) |-> $past(scl, 6))
    else $error("target data late after clock fall");
  // Clock phases last at least one quarter of the bench bit time.
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low too short");
  AST_START: assert property ($fell(sda) && scl |-> scl[*4])
    else $error("start not held");
  AST_STOP: assert property ($rose(sda) && scl |-> scl[*8])
    else $error("stop not held");
  AST_NO_FIGHT: assert property (scl |-> !(t_sda_oe && m_sda_oe))
    else $error("both ends drive while clock high");
endmodule

/* sim/tb.sv */
// Self-checking bench joining the master end to the target end.
`timescale 1ns/1ps
module tb
  import ee_pkg::*;
;
  logic            clk_sys = 1'b0;
  logic            rst_n = 1'b0;
  logic            cmd_valid = 1'b0;
  logic            cmd_ready;
  ee_cmd_kind_type cmd_kind = EE_CMD_WRITE;
  logic [11:0]     cmd_addr = 12'h000;
  logic [4:0]      cmd_len = 5'h00;
  logic            wr_valid = 1'b0;
  logic            wr_ready;
  logic [7:0]      wr_data = 8'h00;
  logic            rd_valid;
  logic            done;
  logic            err;
  logic            busy;
  logic            ready;
  logic [7:0]      rd_data;
  logic            wp = 1'b0;
  logic [2:0]      sel = 3'h5;
  logic [7:0]      model [0:4095];
  logic [11:0]     cur = 12'h000;
  int              num_errors = 0;
  int              n_compared = 0;

  ee_if i_ee_if ();
  ee_target #(.PROG_CYCLES(2000), .POR_CYCLES(16)) i_ee_target (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(i_ee_if.target), .chip_select_pins(sel),
    .write_protect(wp), .busy(busy), .ready(ready));
  ee_master #(.QUARTER(8), .PWRUP_CYCLES(50), .FIFO_DEPTH(4)) i_ee_master (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(i_ee_if.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_sel(sel), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .err(err));
  ee_link_properties i_ee_link_properties (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl(i_ee_if.scl), .m_sda_o(i_ee_if.m_sda_o),
    .m_sda_oe(i_ee_if.m_sda_oe), .t_sda_o(i_ee_if.t_sda_o), .t_sda_oe(i_ee_if.t_sda_oe),
    .sda(i_ee_if.sda));

  // Free-running 200 MHz system clock.
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic expect_eq(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Runs one command; write data streams in parallel, read bytes are checked on arrival.
  task automatic run(input ee_cmd_kind_type k, input logic [11:0] a, input logic [4:0] n,
                     input logic [7:0] base, output logic hit);
    logic [11:0] ra;
    int          t;
    int          nb;
    hit = 1'b0;
    t = 0;
    nb = 0;
    ra = (k == EE_CMD_READ_CUR) ? cur : a;
    fork
      if (k == EE_CMD_WRITE) begin
        for (int i = 0; i <= n; i++) begin
          wr_valid <= 1'b1;
          wr_data <= base + i[7:0];
          do @(negedge clk_sys); while (!wr_ready);
          @(posedge clk_sys);
        end
        wr_valid <= 1'b0;
      end
      begin
        cmd_kind <= k;
        cmd_addr <= a;
        cmd_len <= n;
        cmd_valid <= 1'b1;
        do @(negedge clk_sys); while (!cmd_ready);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        while (!done && t < 20000) begin
          @(negedge clk_sys);
          t++;
          hit |= busy;
          expect_eq({7'h0, err}, 8'h00);
          if (rd_valid) begin
            expect_eq(rd_data, model[ra]);
            ra++;
            nb++;
          end
        end
        expect_eq({7'h0, done}, 8'h01);
        // A read that stops early would otherwise pass unnoticed.
        if (k != EE_CMD_WRITE) begin
          expect_eq(nb[7:0], {3'h0, n} + 8'h01);
        end
      end
    join
    // The expected counter follows the in-page wrap of writes.
    if (k == EE_CMD_WRITE) begin
      for (int i = 0; i <= n && !wp; i++) model[{a[11:5], a[4:0] + i[4:0]}] = base + i[7:0];
      cur = {a[11:5], a[4:0] + n + 5'h01};
    end else begin
      cur = ra;
    end
    @(posedge clk_sys);
  endtask

  task automatic test_page_wrap();
    logic h;
    run(EE_CMD_WRITE, 12'hffe, 5'h03, 8'h10, h);
    expect_eq({7'h0, h}, 8'h01);
    run(EE_CMD_READ_RAND, 12'hfe0, 5'h01, 8'h00, h);
    run(EE_CMD_READ_RAND, 12'hffe, 5'h01, 8'h00, h);
  endtask

  task automatic test_array_wrap();
    logic h;
    run(EE_CMD_WRITE, 12'h000, 5'h01, 8'h40, h);
    run(EE_CMD_READ_RAND, 12'hffe, 5'h03, 8'h00, h);
  endtask

  task automatic test_current();
    logic h;
    // A second select value shows that the device byte follows the pins.
    sel <= 3'h2;
    run(EE_CMD_READ_RAND, 12'hffe, 5'h00, 8'h00, h);
    run(EE_CMD_READ_CUR, 12'h000, 5'h01, 8'h00, h);
  endtask

  // A protected write must leave the array alone, while a later byte write lands.
  task automatic test_protect();
    logic h;
    wp <= 1'b1;
    run(EE_CMD_WRITE, 12'h001, 5'h00, 8'hee, h);
    expect_eq({7'h0, h}, 8'h00);
    wp <= 1'b0;
    run(EE_CMD_WRITE, 12'h002, 5'h00, 8'h77, h);
    run(EE_CMD_READ_RAND, 12'h000, 5'h02, 8'h00, h);
  endtask

  task automatic final_report();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset, wait for the master's power-up delay, then the scenarios.
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    do @(negedge clk_sys); while (!cmd_ready);
    expect_eq({7'h0, ready}, 8'h01);
    @(posedge clk_sys);
    test_page_wrap();
    test_array_wrap();
    test_current();
    test_protect();
    final_report();
  end

  // Watchdog well beyond the expected run of some twenty-five thousand cycles.
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
endmodule
